// ---- hdl/mpsc_pkg.sv ----
package mpsc_pkg;

  // Pin widths
  localparam int ADDR_LO_W = 8;
  localparam int ADDR_HI_W = 5;
  localparam int DATA_W = 16;
  localparam int SIG_W = 3;
  localparam int CFGA_W = 8;

  // Field positions within the upper address pins while reset is held
  localparam int POS_BUS_WIDTH = 0;
  localparam int POS_CFG_SRC = 1;
  localparam int POS_SIG_LO = 2;

  // Serial EEPROM lines on the low data pins
  localparam int POS_EE_DO = 0;
  localparam int POS_EE_DI = 1;
  localparam int POS_EE_SK = 2;

  // Serial read: words fetched, bits per command and per word
  localparam int EE_WORDS = 16;
  localparam int EE_CMD_BITS = 9;
  localparam int EE_WORD_BITS = 16;
  localparam logic [2:0] EE_READ_OP = 3'h6;
  // Serial clock half period: 1 us at 25 MHz, longest time rounds down
  localparam int EE_HALF_NS = 1000;
  localparam int CLK_NS = 40;
  localparam int EE_HALF_CYC = EE_HALF_NS / CLK_NS;

  // Reset values
  localparam logic [CFGA_W-1:0] CFGA_RST = 8'h00;
  localparam logic [SIG_W-1:0] SIG_RST = 3'h0;

  typedef enum logic [3:0] {
    MPSC_IDLE = 4'h1,
    MPSC_SETUP = 4'h2,
    MPSC_STROBE = 4'h4,
    MPSC_DONE = 4'h8
  } mpsc_acc_t;

  typedef enum logic [1:0] {
    MPSC_TGT_RAM = 2'h0,
    MPSC_TGT_BOOT = 2'h1,
    MPSC_TGT_EEPROM = 2'h2
  } mpsc_tgt_t;

  typedef struct packed {
    logic bus_width_16;
    logic config_from_eeprom;
    logic [SIG_W-1:0] signature_top;
    logic [CFGA_W-1:0] config_a;
  } mpsc_straps_t;

  typedef struct packed {
    logic valid;
    logic write;
    mpsc_tgt_t target;
    logic [ADDR_HI_W+ADDR_LO_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mpsc_req_t;

endpackage

// ---- hdl/mpsc_eeprom_reader.sv ----
`timescale 1ns/1ps
module mpsc_eeprom_reader (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Control
  input wire logic start,
  output logic busy,
  output logic done,
  // Serial lines
  output logic ee_sk,
  output logic ee_di,
  output logic ee_cs,
  input wire logic ee_do,
  // Loaded contents
  output logic [mpsc_pkg::EE_WORDS*mpsc_pkg::DATA_W-1:0] words
);

  typedef struct packed {
    logic busy;
    logic done;
    logic sk;
    logic [7:0] div;
    logic [4:0] bit_cnt;
    logic [3:0] word;
    logic cmd_phase;
    logic [mpsc_pkg::EE_CMD_BITS-1:0] shreg;
    logic [mpsc_pkg::DATA_W-1:0] rx;
    logic [mpsc_pkg::EE_WORDS*mpsc_pkg::DATA_W-1:0] mem;
  } mpsc_ee_st_t;

  mpsc_ee_st_t st;
  mpsc_ee_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (start && !st.busy) begin
      next_st.busy = 1'b1;
      next_st.word = 4'h0;
      next_st.cmd_phase = 1'b1;
      next_st.bit_cnt = 5'h0;
      next_st.div = 8'h00;
      next_st.sk = 1'b0;
      next_st.shreg = {mpsc_pkg::EE_READ_OP, 6'h00};
    end else if (st.busy) begin
      if (st.div == 8'(mpsc_pkg::EE_HALF_CYC - 1)) begin
        next_st.div = 8'h00;
        next_st.sk = !st.sk;
        if (st.sk) begin
          // Falling edge: advance the bit
          if (st.cmd_phase) begin
            next_st.shreg = {st.shreg[mpsc_pkg::EE_CMD_BITS-2:0], 1'b0};
            if (st.bit_cnt == 5'(mpsc_pkg::EE_CMD_BITS - 1)) begin
              next_st.cmd_phase = 1'b0;
              next_st.bit_cnt = 5'h0;
            end else begin
              next_st.bit_cnt = st.bit_cnt + 5'h1;
            end
          end else if (st.bit_cnt == 5'(mpsc_pkg::EE_WORD_BITS - 1)) begin
            next_st.mem[st.word*mpsc_pkg::DATA_W +: mpsc_pkg::DATA_W] = st.rx;
            next_st.bit_cnt = 5'h0;
            next_st.cmd_phase = 1'b1;
            next_st.word = st.word + 4'h1;
            next_st.shreg = {mpsc_pkg::EE_READ_OP, 2'h0, st.word + 4'h1};
            if (st.word == 4'(mpsc_pkg::EE_WORDS - 1)) begin
              next_st.busy = 1'b0;
              next_st.done = 1'b1;
              next_st.sk = 1'b0;
            end
          end else begin
            next_st.bit_cnt = st.bit_cnt + 5'h1;
          end
        end else if (!st.cmd_phase) begin
          // Rising edge: sample the part's output
          next_st.rx = {st.rx[mpsc_pkg::DATA_W-2:0], ee_do};
        end
      end else begin
        next_st.div = st.div + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy = st.busy;
  assign done = st.done;
  assign ee_sk = st.sk;
  assign ee_di = st.cmd_phase & st.shreg[mpsc_pkg::EE_CMD_BITS-1];
  assign ee_cs = st.busy;
  assign words = st.mem;

endmodule

// ---- hdl/mpsc_top.sv ----
`timescale 1ns/1ps
module mpsc_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Memory access request from the core
  input mpsc_pkg::mpsc_req_t req,
  output logic req_ready,
  output logic rd_valid,
  output logic [mpsc_pkg::DATA_W-1:0] rd_data,
  // Address pins; only the upper pins also have an input, for the strap reads
  input wire logic [mpsc_pkg::ADDR_HI_W-1:0] memory_addr_upper_pins_in,
  output logic [mpsc_pkg::ADDR_HI_W-1:0] memory_addr_upper_pins_out,
  output logic memory_addr_upper_pins_oe,
  output logic [mpsc_pkg::ADDR_LO_W-1:0] memory_addr_lower_pins_out,
  output logic memory_addr_lower_pins_oe,
  // Data pins
  input wire logic [mpsc_pkg::DATA_W-1:0] memory_support_data_in,
  output logic [mpsc_pkg::DATA_W-1:0] memory_support_data_out,
  output logic [mpsc_pkg::DATA_W-1:0] memory_support_data_oe,
  // Strobes and selects, active low
  output logic mem_read_n,
  output logic mem_write_n,
  output logic ram_select_n,
  output logic boot_rom_select_n,
  output logic eeprom_chip_select_n,
  // Captured configuration
  output mpsc_pkg::mpsc_straps_t straps,
  output logic eeprom_load_busy,
  output logic [mpsc_pkg::EE_WORDS*mpsc_pkg::DATA_W-1:0] eeprom_words
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: straps are sampled while reset is low, so the sync
  // chains run on a clean, separate reset-free path.

  typedef struct packed {
    logic [mpsc_pkg::ADDR_HI_W-1:0] hi_s1;
    logic [mpsc_pkg::ADDR_HI_W-1:0] hi_s2;
    logic [mpsc_pkg::DATA_W-1:0] d_s1;
    logic [mpsc_pkg::DATA_W-1:0] d_s2;
  } mpsc_sync_t;

  mpsc_sync_t sy;
  mpsc_sync_t next_sy;

  always_comb begin
    next_sy.hi_s1 = memory_addr_upper_pins_in;
    next_sy.hi_s2 = sy.hi_s1;
    next_sy.d_s1 = memory_support_data_in;
    next_sy.d_s2 = sy.d_s1;
  end

  always_ff @(posedge mclk) begin
    sy <= next_sy;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Strap capture: the async reset may only load constants, so the strap
  // value is tracked by a clocked load while a reset-held flag is low.

  typedef struct packed {
    logic run;
    logic ee_started;
    mpsc_pkg::mpsc_acc_t acc;
    mpsc_pkg::mpsc_req_t cur;
    logic rdv;
    logic [mpsc_pkg::DATA_W-1:0] rdata;
  } mpsc_st_t;

  mpsc_st_t st;
  mpsc_st_t next_st;
  logic ee_busy;
  logic ee_sk;
  logic ee_di;
  logic ee_cs;
  logic strap_hold_n;
  logic [1:0] strap_rel;

  // Strap flag: cleared asynchronously, released two clocks after reset goes high
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      strap_rel <= 2'h0;
    end else begin
      strap_rel <= {strap_rel[0], 1'b1};
    end
  end
  assign strap_hold_n = strap_rel[1];

  // Straps follow the pins while held in reset and freeze afterwards
  always_ff @(posedge mclk) begin
    if (!strap_hold_n) begin
      straps.bus_width_16 <= sy.hi_s2[mpsc_pkg::POS_BUS_WIDTH];
      straps.config_from_eeprom <= sy.hi_s2[mpsc_pkg::POS_CFG_SRC];
      straps.signature_top <= sy.hi_s2[mpsc_pkg::POS_SIG_LO +: mpsc_pkg::SIG_W];
      straps.config_a <= sy.d_s2[mpsc_pkg::CFGA_W-1:0];
    end
  end
  // no other load path exists for straps

  ////////////////////////////////////////////////////////////////////////////////
  // Access sequencer

  always_comb begin
    next_st = st;
    next_st.rdv = 1'b0;
    next_st.run = strap_hold_n;
    if (strap_hold_n && !st.ee_started && straps.config_from_eeprom) begin
      next_st.ee_started = 1'b1;
    end
    unique case (st.acc)
      mpsc_pkg::MPSC_IDLE: begin
        if (req.valid && req_ready) begin
          next_st.cur = req;
          next_st.acc = mpsc_pkg::MPSC_SETUP;
        end
      end
      mpsc_pkg::MPSC_SETUP: begin
        next_st.acc = mpsc_pkg::MPSC_STROBE;
      end
      mpsc_pkg::MPSC_STROBE: begin
        next_st.acc = mpsc_pkg::MPSC_DONE;
      end
      mpsc_pkg::MPSC_DONE: begin
        // Pin data from the setup cycle has now passed both sync flops
        if (!st.cur.write) begin
          next_st.rdata = sy.d_s2;
          next_st.rdv = 1'b1;
        end
        next_st.acc = mpsc_pkg::MPSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st <= '{run: 1'b0, ee_started: 1'b0, acc: mpsc_pkg::MPSC_IDLE,
              cur: '0, rdv: 1'b0, rdata: '0};
    end else begin
      st <= next_st;
    end
  end

  mpsc_eeprom_reader u_ee (
    .mclk(mclk),
    .resetn(resetn),
    .start(st.ee_started && !st.run ? 1'b0 : (strap_hold_n && straps.config_from_eeprom
           && !st.ee_started)),
    .busy(ee_busy),
    .done(),
    .ee_sk(ee_sk),
    .ee_di(ee_di),
    .ee_cs(ee_cs),
    .ee_do(sy.d_s2[mpsc_pkg::POS_EE_DO]),
    .words(eeprom_words)
  );

  // Accesses wait until straps are frozen and the EEPROM load is over
  assign req_ready = st.run && !ee_busy && (st.acc == mpsc_pkg::MPSC_IDLE);
  assign eeprom_load_busy = ee_busy;
  assign rd_valid = st.rdv;
  assign rd_data = st.rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drive

  logic active;
  logic strobe;
  logic [mpsc_pkg::DATA_W-1:0] data_oe;
  assign active = (st.acc != mpsc_pkg::MPSC_IDLE);
  assign strobe = (st.acc == mpsc_pkg::MPSC_STROBE);

  assign memory_addr_upper_pins_oe = resetn;
  assign memory_addr_upper_pins_out = st.cur.addr[mpsc_pkg::ADDR_HI_W+mpsc_pkg::ADDR_LO_W-1:
                                                  mpsc_pkg::ADDR_LO_W];
  assign memory_addr_lower_pins_oe = resetn;
  assign memory_addr_lower_pins_out = st.cur.addr[mpsc_pkg::ADDR_LO_W-1:0];

  // Read strobe spans the whole RAM or boot read, none for EEPROM reads: the two sync flops need the data early
  assign mem_read_n = !(active && !st.cur.write
                        && st.cur.target != mpsc_pkg::MPSC_TGT_EEPROM);
  assign mem_write_n = !(strobe && st.cur.write && st.cur.target == mpsc_pkg::MPSC_TGT_RAM);
  assign ram_select_n = !(active && st.cur.target == mpsc_pkg::MPSC_TGT_RAM);
  assign boot_rom_select_n = !(active && !st.cur.write
                               && st.cur.target == mpsc_pkg::MPSC_TGT_BOOT);
  // Serial part is selected during its load and for parallel reads of it
  assign eeprom_chip_select_n = !(ee_cs || (active && !st.cur.write
                                  && st.cur.target == mpsc_pkg::MPSC_TGT_EEPROM));

  // Low data pins carry the serial lines only while the load runs
  always_comb begin
    data_oe = {mpsc_pkg::DATA_W{active && st.cur.write && st.cur.target == mpsc_pkg::MPSC_TGT_RAM
               && resetn}};
    memory_support_data_out = st.cur.wdata;
    if (ee_busy) begin
      data_oe[mpsc_pkg::POS_EE_DO] = 1'b0;
      data_oe[mpsc_pkg::POS_EE_DI] = 1'b1;
      data_oe[mpsc_pkg::POS_EE_SK] = 1'b1;
      memory_support_data_out[mpsc_pkg::POS_EE_DI] = ee_di;
      memory_support_data_out[mpsc_pkg::POS_EE_SK] = ee_sk;
    end
  end
  assign memory_support_data_oe = data_oe;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence strobe_seq;
    st.acc == mpsc_pkg::MPSC_SETUP ##1 st.acc == mpsc_pkg::MPSC_STROBE
      ##1 st.acc == mpsc_pkg::MPSC_DONE;
  endsequence

  strap_freeze_a: assert property (@(posedge mclk) disable iff (!resetn)
    strap_hold_n && $past(strap_hold_n) |-> $stable(straps))
    else $error("straps changed after release");
  addr_drive_a: assert property (@(posedge mclk) disable iff (!resetn)
    memory_addr_upper_pins_oe)
    else $error("upper address not driven");
  read_data_a: assert property (@(posedge mclk) disable iff (!resetn)
    strobe_seq ##0 !st.cur.write |=> rd_valid && rd_data == $past(sy.d_s2))
    else $error("read data not captured");
  write_drive_a: assert property (@(posedge mclk) disable iff (!resetn)
    !mem_write_n |-> memory_support_data_oe[mpsc_pkg::DATA_W-1])
    else $error("write without data drive");
  ram_select_a: assert property (@(posedge mclk) disable iff (!resetn)
    (!mem_write_n || (!mem_read_n && st.cur.target == mpsc_pkg::MPSC_TGT_RAM)) |-> !ram_select_n)
    else $error("ram access without select");
  boot_read_a: assert property (@(posedge mclk) disable iff (!resetn)
    !boot_rom_select_n |-> !st.cur.write && mem_write_n)
    else $error("boot select on write");
  eeprom_select_a: assert property (@(posedge mclk) disable iff (!resetn)
    ee_busy |-> !eeprom_chip_select_n)
    else $error("eeprom load without select");
  pins_return_a: assert property (@(posedge mclk) disable iff (!resetn)
    $fell(ee_busy) |-> !memory_support_data_oe[mpsc_pkg::POS_EE_SK]
                       || st.acc != mpsc_pkg::MPSC_IDLE)
    else $error("serial pins still driven");
  strap_width_a: assert property (@(posedge mclk)
    $rose(strap_hold_n) |-> straps.bus_width_16 == $past(sy.hi_s2[mpsc_pkg::POS_BUS_WIDTH]))
    else $error("width strap wrong");

endmodule

// ---- dv/mpsc_mem_model.sv ----
`timescale 1ns/1ps
module mpsc_mem_model (
  // Clock
  input wire logic mclk,
  // Pins from the block
  input wire logic [12:0] addr,
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe,
  input wire logic mem_read_n,
  input wire logic mem_write_n,
  input wire logic ram_select_n,
  input wire logic boot_rom_select_n,
  input wire logic eeprom_chip_select_n,
  // Board pull-ups on the low data pins
  input wire logic [7:0] cfga_pull,
  // Resolved data pins
  output logic [15:0] data_in
);
  logic [15:0] ram [0:8191];
  logic [15:0] drv;
  logic [15:0] flt_all;
  logic drv_en;
  logic [7:0] flt = 8'h5A;
  logic [8:0] cmd = 9'h000;
  logic [15:0] word;
  logic do_bit = 1'b1;
  int bits = 0;
  // Clock only counts while the part is selected, so parallel writes leave it alone
  wire sk = !eeprom_chip_select_n & data_oe[2] & data_out[2];

  function automatic logic [15:0] ee_val(input logic [5:0] a);
    return 16'hC300 ^ {a, 4'hA, a};
  endfunction

  function automatic logic [15:0] rom_val(input logic [12:0] a);
    return {3'h5, a};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Upper byte floats: a moving pattern so a stale value never passes
  always @(posedge mclk) begin
    flt <= flt + 8'h01;
    if (!ram_select_n && !mem_write_n) begin
      ram[addr] <= data_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial part: 9 command bits in, then 16 data bits out, changed on falling clock
  always @(posedge sk) begin
    if (bits == 25) begin
      bits = 0;
    end
    cmd = {cmd[7:0], data_out[1]};
    bits = bits + 1;
  end

  always @(negedge sk) begin
    if (bits == 9) begin
      word = ee_val(cmd[5:0]);
    end
    if (bits >= 9 && bits <= 24) begin
      do_bit = word[24 - bits];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parts only drive while selected and enabled; data gone as soon as released
  always_comb begin
    drv_en = 1'b1;
    drv = 16'h0000;
    flt_all = {flt, cfga_pull};
    if (data_oe[2]) begin
      flt_all[0] = do_bit;
    end
    if (!ram_select_n && !mem_read_n) begin
      drv = ram[addr];
    end else if (!boot_rom_select_n && !mem_read_n) begin
      drv = rom_val(addr);
    end else if (!eeprom_chip_select_n && !data_oe[2]) begin
      drv = ee_val(addr[5:0]);
    end else begin
      drv_en = 1'b0;
    end
    for (int i = 0; i < 16; i++) begin
      data_in[i] = data_oe[i] ? data_out[i] : (drv_en ? drv[i] : flt_all[i]);
    end
  end
endmodule

// ---- dv/mpsc_top_tb.sv ----
`timescale 1ns/1ps
module mpsc_top_tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  mpsc_pkg::mpsc_req_t req = '0;
  logic [4:0] strap_pins = 5'h00;
  logic [7:0] cfga_pull = 8'h00;
  logic [4:0] up_in, up_out, s;
  logic [7:0] lo_out;
  logic [15:0] d_in, d_out, d_oe, rd_data, q, wd, sexp;
  logic up_oe, lo_oe, req_ready, rd_valid, busy, cur_write;
  logic mem_read_n, mem_write_n, ram_select_n, boot_rom_select_n, eeprom_chip_select_n;
  logic [12:0] a, cur_addr;
  logic [255:0] eeprom_words;
  mpsc_pkg::mpsc_straps_t straps;
  int fails = 0;
  int cmp_count = 0;
  int seed = 32'h8075;
  int cyc = 0;
  int n;

  always #20 mclk = ~mclk;
  // Straps show only while the block leaves the upper pins undriven
  assign up_in = up_oe ? up_out : strap_pins;

  mpsc_top dut (.mclk(mclk), .resetn(resetn), .req(req), .req_ready(req_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .memory_addr_upper_pins_in(up_in),
    .memory_addr_upper_pins_out(up_out), .memory_addr_upper_pins_oe(up_oe),
    .memory_addr_lower_pins_out(lo_out), .memory_addr_lower_pins_oe(lo_oe),
    .memory_support_data_in(d_in), .memory_support_data_out(d_out),
    .memory_support_data_oe(d_oe), .mem_read_n(mem_read_n), .mem_write_n(mem_write_n),
    .ram_select_n(ram_select_n), .boot_rom_select_n(boot_rom_select_n),
    .eeprom_chip_select_n(eeprom_chip_select_n), .straps(straps),
    .eeprom_load_busy(busy), .eeprom_words(eeprom_words));

  mpsc_mem_model mdl (.mclk(mclk), .addr({up_out, lo_out}), .data_out(d_out), .data_oe(d_oe),
    .mem_read_n(mem_read_n), .mem_write_n(mem_write_n), .ram_select_n(ram_select_n),
    .boot_rom_select_n(boot_rom_select_n), .eeprom_chip_select_n(eeprom_chip_select_n),
    .cfga_pull(cfga_pull), .data_in(d_in));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [15:0] exp_ee(input logic [5:0] ad);
    return 16'hC300 ^ {ad, 4'hA, ad};
  endfunction

  function automatic logic [15:0] exp_rom(input logic [12:0] ad);
    return {3'h5, ad};
  endfunction

  task automatic conclude;
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      $display("[FAIL] %0t run did not complete", $time);
      conclude();
    end
  end

  // Any select in a parallel access must carry that access's address
  always @(negedge mclk) begin
    if (resetn && !busy && !(ram_select_n && boot_rom_select_n && eeprom_chip_select_n)) begin
      chk(16'({up_out, lo_out}), 16'(cur_addr), "address pins");
      if (!boot_rom_select_n) chk(16'(cur_write), 16'h0000, "boot select on write");
    end
  end

  task automatic do_reset(input logic [4:0] st, input logic [7:0] c);
    @(posedge mclk);
    resetn <= 1'b0;
    strap_pins <= st;
    cfga_pull <= c;
    repeat (5) @(posedge mclk);
    chk(16'(up_oe), 16'h0000, "oe in reset");
    resetn <= 1'b1;
    repeat (4) @(negedge mclk);
    chk(16'({up_oe, lo_oe}), 16'h0003, "oe out of reset");
    chk(16'(straps), {3'h0, st[0], st[1], st[4:2], c}, "straps");
    sexp = {3'h0, st[0], st[1], st[4:2], c};
    @(posedge mclk);
    strap_pins <= ~st;
    cfga_pull <= ~c;
    repeat (8) @(negedge mclk);
    chk(16'(straps), {3'h0, st[0], st[1], st[4:2], c}, "straps held");
  endtask

  task automatic acc(input logic w, input mpsc_pkg::mpsc_tgt_t t, input logic [12:0] ad,
                     input logic [15:0] d, output logic [15:0] r);
    int k;
    k = 0;
    r = 16'h0000;
    @(posedge mclk);
    req <= {1'b1, w, t, ad, d};
    cur_addr = ad;
    cur_write = w;
    @(negedge mclk);
    while (req_ready !== 1'b1 && k < 50) begin
      k++;
      @(negedge mclk);
    end
    if (k == 50) chk(16'h0000, 16'h0001, "request never taken");
    @(posedge mclk);
    req.valid <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    if (!w) chk(16'(rd_valid), 16'h0001, "read answer timing");
    r = rd_data;
  endtask

  initial begin
    for (int k = 0; k < 3; k++) begin
      s = 5'($random(seed));
      s[1] = 1'b0;
      do_reset(s, 8'($random(seed)));
    end
    do_reset(5'($random(seed)) | 5'h02, 8'($random(seed)));
    chk(16'(busy), 16'h0001, "serial load running");
    n = 0;
    while (busy !== 1'b0 && n < 30000) begin
      n++;
      @(negedge mclk);
    end
    for (int i = 0; i < 16; i++) chk(eeprom_words[16*i+:16], exp_ee(6'(i)), "ee word");
    chk(16'(d_oe[2:0]), 16'h0000, "serial pins released");
    for (int k = 0; k < 20; k++) begin
      a = (k == 0) ? 13'h1FFF : 13'($random(seed));
      wd = (k == 1) ? 16'h0007 : 16'($random(seed));
      acc(1'b1, mpsc_pkg::MPSC_TGT_RAM, a, wd, q);
      acc(1'b0, mpsc_pkg::MPSC_TGT_RAM, a, 16'h0000, q);
      chk(q, wd, "ram readback");
      acc(1'b0, mpsc_pkg::MPSC_TGT_BOOT, a, 16'h0000, q);
      chk(q, exp_rom(a), "boot read");
      acc(1'b0, mpsc_pkg::MPSC_TGT_EEPROM, a, 16'h0000, q);
      chk(q, exp_ee(a[5:0]), "eeprom read");
    end
    acc(1'b1, mpsc_pkg::MPSC_TGT_BOOT, a, wd, q);
    chk(16'(straps), sexp, "straps after traffic");
    conclude();
  end
endmodule
